// file: inc/ccr_pkg.sv
// Purpose: Shared constants for the core control register bank
// Assumes: Byte-wide registers reached over a two-wire serial slave
// Notes: Register addresses are the register numbers 0 to 3
// =====================================================================
// Package
package ccr_pkg;
  // Seven-bit target address on the two-wire bus
  localparam logic [6:0] CCR_DEV_ADDR = 7'h08;
  // Register addresses
  localparam logic [7:0] CCR_ADDR_CHIP = 8'h00;
  localparam logic [7:0] CCR_ADDR_TX = 8'h01;
  localparam logic [7:0] CCR_ADDR_LOOP = 8'h02;
  localparam logic [7:0] CCR_ADDR_CONV = 8'h03;
  // Reset values
  localparam logic [7:0] CCR_DEF_CHIP = 8'h41;
  localparam logic [7:0] CCR_DEF_TX = 8'h00;
  localparam logic [7:0] CCR_DEF_LOOP = 8'h00;
  localparam logic [7:0] CCR_DEF_CONV = 8'h00;
  // Chip register fields
  localparam int CCR_GLOBAL_RST_BIT = 7;
  localparam int CCR_REG_RST_BIT = 1;
  localparam int CCR_CHIP_EN_BIT = 0;
  localparam logic [7:0] CCR_SC_MASK = 8'h82;
  // Transmit bias register fields
  localparam int CCR_PD_FAULT_BIT = 7;
  localparam int CCR_PD_RANGE_HI = 6;
  localparam int CCR_PD_RANGE_LO = 5;
  localparam int CCR_OPEN_LOOP_BIT = 4;
  localparam int CCR_FAULT_EN_BIT = 3;
  localparam int CCR_BIAS_EN_BIT = 2;
  localparam int CCR_BIAS_SINK_BIT = 1;
  localparam int CCR_PD_POL_BIT = 0;
  // Loopback register fields
  localparam int CCR_OPT_LB_BIT = 1;
  localparam int CCR_ELEC_LB_BIT = 0;
  // Converter register fields
  localparam int CCR_CONV_EN_BIT = 7;
  localparam int CCR_OSC_EN_BIT = 6;
  localparam int CCR_CONV_RST_BIT = 4;
  localparam int CCR_SEL_HI = 2;
  localparam int CCR_SEL_LO = 0;
  // Converter input codes
  localparam logic [2:0] CCR_SEL_TEMP = 3'h0;
  localparam logic [2:0] CCR_SEL_SUPPLY = 3'h1;
  localparam logic [2:0] CCR_SEL_BIAS_MON = 3'h2;
  localparam logic [2:0] CCR_SEL_PD_MON = 3'h3;
  // Bits in a byte
  localparam logic [3:0] CCR_BYTE_BITS = 4'h8;
  // Serial slave states
  typedef enum logic [3:0] {
    CCR_IDLE = 4'h0,
    CCR_DEVADR = 4'h1,
    CCR_ACK_DEV = 4'h2,
    CCR_REGADR = 4'h3,
    CCR_ACK_REG = 4'h4,
    CCR_WDATA = 4'h5,
    CCR_ACK_WR = 4'h6,
    CCR_RDATA = 4'h7,
    CCR_HOST_ACK = 4'h8,
    CCR_WAIT = 4'h9
  } ccr_state_t;
endpackage : ccr_pkg

// file: src/ccr_pin_filter.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Output follows only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Pin filter
module ccr_pin_filter #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1; // First stage, read only by s2
  logic s2; // Second stage
  logic s3; // Third stage

  // Synchroniser chain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once two stages agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level <= RESET_LEVEL;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule : ccr_pin_filter
`default_nettype wire

// file: src/ccr_bank.sv
// Purpose: Core control register bank behind a two-wire serial slave
// Assumes: Host runs the bus far slower than clk
// Notes: One data byte per transfer; reads use a preset address
// =====================================================================
// Overview of operation
// - Bit 7 write resets register pointer, registers
// - Bit 1 write restores all registers' defaults
// - Self-clearing bits always read as zero
// - Bit 0 is chip enable, default one
// - First register reads 41h after reset
// - Bit 7 gates photodiode monitor fault trigger
// - Bits 6:5 select photodiode current range
// - Bit 4 chooses open or closed loop
// - Bit 3 switches fault detection
// - Bit 2 enables bias; clearing it clears fault
// - Bit 1 chooses bias sink or source
// - Bit 0 sets photodiode polarity
// - Loopback bit 1 selects optical loopback
// - Loopback bit 0 selects electrical loopback
// - Converter bit 7 enables converter
// - Converter bit 6 enables its oscillator
// - Converter bit 4 holds converter reset
// - Converter bits 2:0 select monitored input
// - Fixed address, direction, register, one data byte
// - Power-on reset loads every default
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Register bank top
module ccr_bank
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Chip controls
  output logic chip_enable,
  output logic global_soft_reset,
  output logic reg_soft_reset,
  // Transmit bias controls
  output logic pd_monitor_fault_trigger,
  output logic pd_range_high,
  output logic pd_range_low,
  output logic open_loop_select,
  output logic fault_detect_enable,
  output logic laser_bias_enable,
  output logic fault_clear,
  output logic bias_sink_select,
  output logic photodiode_polarity,
  // Loopback controls
  output logic optical_loopback_select,
  output logic electrical_loopback_select,
  // Monitor converter controls
  output logic converter_enable,
  output logic converter_osc_enable,
  output logic converter_reset,
  output logic converter_input_sel_2,
  output logic converter_input_sel_1,
  output logic converter_input_sel_0
);
  // ===================================================================
  // Declarations
  logic scl_f; // Filtered clock line
  logic sda_f; // Filtered data line
  logic scl_d; // Clock line one cycle ago
  logic sda_d; // Data line one cycle ago
  logic scl_rise; // Clock rising edge
  logic scl_fall; // Clock falling edge
  logic bus_start; // Start or repeated start
  logic bus_stop; // Stop condition
  ccr_state_t state; // Slave state
  logic [3:0] bit_cnt; // Bits moved in current byte
  logic [7:0] shreg; // Shift register
  logic [7:0] reg_ptr; // Register pointer
  logic wr_en; // One-cycle write strobe
  logic [7:0] wr_data; // Write data
  logic [7:0] reg_chip; // Chip register, self-clearing bits zero
  logic [7:0] reg_tx; // Transmit bias register
  logic [7:0] reg_loop; // Loopback register
  logic [7:0] reg_conv; // Converter register
  logic soft_any; // Either soft reset pulse
  logic [7:0] next_tx; // Next transmit bias value
  logic [7:0] rd_byte; // Byte the pointer selects for a read

  // Read mux, self-clearing bits forced low
  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] c,
                                          input logic [7:0] t, input logic [7:0] l,
                                          input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      CCR_ADDR_CHIP: r = c & ~CCR_SC_MASK;
      CCR_ADDR_TX: r = t;
      CCR_ADDR_LOOP: r = l;
      CCR_ADDR_CONV: r = v;
      default: r = 8'h00; // Unmapped reads zero
    endcase
    return r;
  endfunction : read_reg

  // ===================================================================
  // Pin synchronisers
  ccr_pin_filter #(.RESET_LEVEL(1'b1)) u_scl (
    .clk(clk),
    .rstn(rstn),
    .pin(scl_in),
    .level(scl_f)
  );
  ccr_pin_filter #(.RESET_LEVEL(1'b1)) u_sda (
    .clk(clk),
    .rstn(rstn),
    .pin(sda_in),
    .level(sda_f)
  );

  // Previous line levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Bus events
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
  assign bus_stop = scl_f & scl_d & ~sda_d & sda_f;
  assign sda_out = 1'b0;
  // Read byte for the pointer, self-clearing bits already low
  assign rd_byte = read_reg(reg_ptr, reg_chip, reg_tx, reg_loop, reg_conv);

  // ===================================================================
  // Serial slave state machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CCR_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      sda_oe <= 1'b0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (bus_stop) begin
        // Stop frees the bus
        state <= CCR_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        // Start or repeated start begins address
        state <= CCR_DEVADR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          CCR_DEVADR, CCR_REGADR, CCR_WDATA: begin
            // Sample an incoming bit
            shreg <= {shreg[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end
          CCR_HOST_ACK: state <= CCR_WAIT;
          default: state <= state;
        endcase
      end else if (scl_fall) begin
        unique case (state)
          CCR_DEVADR: begin
            if (bit_cnt == CCR_BYTE_BITS) begin
              if (shreg[7:1] == CCR_DEV_ADDR) begin
                state <= CCR_ACK_DEV;
                sda_oe <= 1'b1;
              end else begin
                state <= CCR_WAIT; // Not ours, stay off the line
              end
            end
          end
          CCR_ACK_DEV: begin
            bit_cnt <= 4'h0;
            if (shreg[0]) begin
              // Read: first data bit out now
              state <= CCR_RDATA;
              shreg <= rd_byte;
              sda_oe <= ~rd_byte[7];
              bit_cnt <= 4'h1;
            end else begin
              state <= CCR_REGADR;
              sda_oe <= 1'b0;
            end
          end
          CCR_REGADR: begin
            if (bit_cnt == CCR_BYTE_BITS) begin
              state <= CCR_ACK_REG;
              sda_oe <= 1'b1;
            end
          end
          CCR_ACK_REG: begin
            state <= CCR_WDATA;
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
          end
          CCR_WDATA: begin
            if (bit_cnt == CCR_BYTE_BITS) begin
              // Byte complete: write and acknowledge
              state <= CCR_ACK_WR;
              sda_oe <= 1'b1;
              wr_en <= 1'b1;
              wr_data <= shreg;
            end
          end
          CCR_ACK_WR: begin
            state <= CCR_WAIT;
            sda_oe <= 1'b0;
          end
          CCR_RDATA: begin
            if (bit_cnt == CCR_BYTE_BITS) begin
              state <= CCR_HOST_ACK;
              sda_oe <= 1'b0;
            end else begin
              // Next bit, most significant first
              sda_oe <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default: state <= state;
        endcase
      end
    end
  end

  // Register pointer, cleared by global reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_ptr <= 8'h00;
    end else if (global_soft_reset) begin
      reg_ptr <= 8'h00;
    end else if (state == CCR_REGADR && scl_fall && bit_cnt == CCR_BYTE_BITS) begin
      reg_ptr <= shreg;
    end
  end

  // ===================================================================
  // Soft reset pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      global_soft_reset <= 1'b0;
      reg_soft_reset <= 1'b0;
    end else begin
      global_soft_reset <= wr_en & (reg_ptr == CCR_ADDR_CHIP) & wr_data[CCR_GLOBAL_RST_BIT];
      reg_soft_reset <= wr_en & (reg_ptr == CCR_ADDR_CHIP) & wr_data[CCR_REG_RST_BIT];
    end
  end
  assign soft_any = global_soft_reset | reg_soft_reset;

  // Chip register, self-clearing bits never stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_chip <= CCR_DEF_CHIP;
    end else if (soft_any) begin
      reg_chip <= CCR_DEF_CHIP;
    end else if (wr_en && reg_ptr == CCR_ADDR_CHIP && (wr_data & CCR_SC_MASK) == 8'h00) begin
      // A reset write stores nothing, so chip enable cannot blink low
      reg_chip <= wr_data & ~CCR_SC_MASK;
    end
  end

  // Next transmit bias value
  always_comb begin
    next_tx = reg_tx;
    if (soft_any) begin
      next_tx = CCR_DEF_TX;
    end else if (wr_en && reg_ptr == CCR_ADDR_TX) begin
      next_tx = wr_data;
    end
  end

  // Transmit bias register and fault clear on bias drop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_tx <= CCR_DEF_TX;
      fault_clear <= 1'b0;
    end else begin
      reg_tx <= next_tx;
      fault_clear <= reg_tx[CCR_BIAS_EN_BIT] & ~next_tx[CCR_BIAS_EN_BIT];
    end
  end

  // Loopback and converter registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_loop <= CCR_DEF_LOOP;
      reg_conv <= CCR_DEF_CONV;
    end else if (soft_any) begin
      reg_loop <= CCR_DEF_LOOP;
      reg_conv <= CCR_DEF_CONV;
    end else if (wr_en) begin
      if (reg_ptr == CCR_ADDR_LOOP) begin
        reg_loop <= wr_data;
      end
      if (reg_ptr == CCR_ADDR_CONV) begin
        reg_conv <= wr_data;
      end
    end
  end

  // ===================================================================
  // Control outputs, straight from register bits
  assign chip_enable = reg_chip[CCR_CHIP_EN_BIT];
  assign pd_monitor_fault_trigger = reg_tx[CCR_PD_FAULT_BIT];
  assign pd_range_high = reg_tx[CCR_PD_RANGE_HI];
  assign pd_range_low = reg_tx[CCR_PD_RANGE_LO];
  assign open_loop_select = reg_tx[CCR_OPEN_LOOP_BIT];
  assign fault_detect_enable = reg_tx[CCR_FAULT_EN_BIT];
  assign laser_bias_enable = reg_tx[CCR_BIAS_EN_BIT];
  assign bias_sink_select = reg_tx[CCR_BIAS_SINK_BIT];
  assign photodiode_polarity = reg_tx[CCR_PD_POL_BIT];
  assign optical_loopback_select = reg_loop[CCR_OPT_LB_BIT];
  assign electrical_loopback_select = reg_loop[CCR_ELEC_LB_BIT];
  assign converter_enable = reg_conv[CCR_CONV_EN_BIT];
  assign converter_osc_enable = reg_conv[CCR_OSC_EN_BIT];
  assign converter_reset = reg_conv[CCR_CONV_RST_BIT];
  assign converter_input_sel_2 = reg_conv[CCR_SEL_HI];
  assign converter_input_sel_1 = reg_conv[CCR_SEL_LO + 1];
  assign converter_input_sel_0 = reg_conv[CCR_SEL_LO];

  // ===================================================================
  // Assertions
  a_sc_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
    (read_reg(CCR_ADDR_CHIP, reg_chip, reg_tx, reg_loop, reg_conv) & CCR_SC_MASK) == 8'h00)
    else $error("self-clearing bit read as one");
  a_global_cause: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && reg_ptr == CCR_ADDR_CHIP && wr_data[7] |=> global_soft_reset ##1 reg_ptr == 8'h00)
    else $error("global reset did not act");
  a_pulse_single: assert property (@(posedge clk) disable iff (!rstn)
    global_soft_reset || reg_soft_reset |=> !global_soft_reset && !reg_soft_reset)
    else $error("soft reset pulse too long");
  a_reg_defaults: assert property (@(posedge clk) disable iff (!rstn)
    reg_soft_reset |=> reg_chip == 8'h41 && reg_tx == 8'h00 && reg_loop == 8'h00
      && reg_conv == 8'h00)
    else $error("register reset left values");
  a_chip_enable: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && reg_ptr == CCR_ADDR_CHIP && (wr_data & CCR_SC_MASK) == 8'h00
      |=> chip_enable == $past(wr_data[0]))
    else $error("chip enable not written");
  a_tx_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && reg_ptr == CCR_ADDR_TX && !soft_any |=>
      {pd_monitor_fault_trigger, pd_range_high, pd_range_low, open_loop_select,
       fault_detect_enable, laser_bias_enable, bias_sink_select, photodiode_polarity}
      == $past(wr_data))
    else $error("bias controls not written");
  a_fault_clear: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $fell(laser_bias_enable) |-> fault_clear)
    else $error("bias drop gave no fault clear");
  a_loop_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && reg_ptr == CCR_ADDR_LOOP && !soft_any |=>
      {optical_loopback_select, electrical_loopback_select} == $past(wr_data[1:0]))
    else $error("loopback select not written");
  a_conv_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && reg_ptr == CCR_ADDR_CONV && !soft_any |=>
      {converter_enable, converter_osc_enable, converter_reset, converter_input_sel_2,
       converter_input_sel_1, converter_input_sel_0} ==
      {$past(wr_data[7:6]), $past(wr_data[4]), $past(wr_data[2:0])})
    else $error("converter controls not written");
  a_addr_ack: assert property (@(posedge clk) disable iff (!rstn)
    state == CCR_ACK_DEV || state == CCR_ACK_REG || state == CCR_ACK_WR |-> sda_oe)
    else $error("acknowledge not driven");
endmodule : ccr_bank
`default_nettype wire

// file: verif/ccr_host_model.sv
// Purpose: Two-wire bus host model driving the register bank
// Assumes: Open-drain data wire resolved in the bench with a pull-up
// Notes: A quarter bit of QTR cycles keeps every level past the pin filter
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Host model
module ccr_host_model
  import ccr_pkg::*;
#(
  parameter int QTR = 6
) (
  // Clock
  input wire logic clk,
  // Bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Idle bus, both lines released and pulled high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bit wait, changes land just after falling edges
  task automatic qwait();
    repeat (QTR) @(negedge clk);
  endtask : qwait
  // One clock pulse; data set while clock low, wire sampled mid-high
  task automatic slot(input logic b, output logic seen);
    sda_low = ~b;
    qwait();
    scl = 1'b1;
    qwait();
    seen = sda;
    qwait();
    scl = 1'b0;
    qwait();
  endtask : slot
  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_low = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sda_low = 1'b1;
    qwait();
    scl = 1'b0;
    qwait();
  endtask : start
  // Stop: data rises while clock high, bus left idle
  task automatic stop();
    sda_low = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sda_low = 1'b0;
    qwait();
  endtask : stop
  // Byte out, most significant bit first, then the acknowledge slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(d[i], s);
    end
    slot(1'b1, s);
    ack = ~s;
  endtask : send
  // Byte in, then a not-acknowledge that ends the read
  task automatic recv(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(1'b1, s);
  endtask : recv
  // Write transfer: one data byte between start and stop
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                           input logic [7:0] d, output logic ok);
    logic k;
    start();
    send({dev, 1'b0}, ok);
    // Abandon the transfer when nobody answers the address
    if (ok) begin
      send(a, k);
      ok = ok & k;
      send(d, k);
      ok = ok & k;
    end
    stop();
  endtask : write_reg
  // Read transfer: set pointer, repeated start, one byte back
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    send({CCR_DEV_ADDR, 1'b0}, k);
    send(a, k);
    start();
    send({CCR_DEV_ADDR, 1'b1}, k);
    recv(d);
    stop();
  endtask : read_reg
endmodule : ccr_host_model
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the core control register bank
// Assumes: Host model runs the bus far slower than clk
// Notes: Integer model of the four registers predicts outputs and reads
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Testbench
module testbench
  import ccr_pkg::*;
;
  // Clock, reset and bus wires
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire logic scl;
  wire logic sda_low;
  wire logic sda;
  // Design outputs
  logic sda_out, sda_oe, chip_enable, global_soft_reset, reg_soft_reset, fault_clear;
  logic pd_monitor_fault_trigger, pd_range_high, pd_range_low, open_loop_select;
  logic fault_detect_enable, laser_bias_enable, bias_sink_select, photodiode_polarity;
  logic optical_loopback_select, electrical_loopback_select, converter_enable;
  logic converter_osc_enable, converter_reset;
  logic converter_input_sel_2, converter_input_sel_1, converter_input_sel_0;
  // Model state and counters
  int exp_reg[4];
  int exp_glob = 0, exp_rsr = 0, exp_fclr = 0, n_glob = 0, n_rsr = 0, n_fclr = 0;
  int mismatches = 0, checks_done = 0, cycles = 0;
  // Open-drain wire with pull-up
  assign sda = (sda_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
  // Clock generator
  always #2.5 clk = ~clk;
  // =====================================================================
  // Instances
  ccr_host_model #(.QTR(6)) u_host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  ccr_bank u_dut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_enable(chip_enable), .global_soft_reset(global_soft_reset),
    .reg_soft_reset(reg_soft_reset), .pd_monitor_fault_trigger(pd_monitor_fault_trigger),
    .pd_range_high(pd_range_high), .pd_range_low(pd_range_low),
    .open_loop_select(open_loop_select), .fault_detect_enable(fault_detect_enable),
    .laser_bias_enable(laser_bias_enable), .fault_clear(fault_clear),
    .bias_sink_select(bias_sink_select), .photodiode_polarity(photodiode_polarity),
    .optical_loopback_select(optical_loopback_select),
    .electrical_loopback_select(electrical_loopback_select),
    .converter_enable(converter_enable), .converter_osc_enable(converter_osc_enable),
    .converter_reset(converter_reset), .converter_input_sel_2(converter_input_sel_2),
    .converter_input_sel_1(converter_input_sel_1),
    .converter_input_sel_0(converter_input_sel_0)
  );
  // =====================================================================
  // Pulse counting and hang guard; a one-cycle pulse counts once
  always @(posedge clk) begin
    cycles++;
    if (global_soft_reset === 1'b1) n_glob++;
    if (reg_soft_reset === 1'b1) n_rsr++;
    if (fault_clear === 1'b1) n_fclr++;
    if (cycles == 90000) begin
      mismatches++;
      complete_run();
    end
  end
  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // One comparison
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Control outputs and pulse counts against the model
  task automatic check_outputs();
    logic [7:0] s1, s2, s3;
    s1 = {pd_monitor_fault_trigger, pd_range_high, pd_range_low, open_loop_select,
          fault_detect_enable, laser_bias_enable, bias_sink_select, photodiode_polarity};
    s3 = {converter_enable, converter_osc_enable, 1'b0, converter_reset, 1'b0,
          converter_input_sel_2, converter_input_sel_1, converter_input_sel_0};
    check("chip enable", 8'(exp_reg[0] & 1), {7'h00, chip_enable});
    check("bias outputs", 8'(exp_reg[1]), s1);
    s2 = {6'h00, optical_loopback_select, electrical_loopback_select};
    check("loopback", 8'(exp_reg[2] & 3), s2);
    check("converter", 8'(exp_reg[3] & 32'hD7), s3);
    check("global pulses", 8'(exp_glob), 8'(n_glob));
    check("register pulses", 8'(exp_rsr), 8'(n_rsr));
    check("fault clear pulses", 8'(exp_fclr), 8'(n_fclr));
  endtask : check_outputs
  // Bus write plus model update
  task automatic wr(input int a, input int d);
    logic ok;
    int old;
    old = exp_reg[1];
    u_host.write_reg(CCR_DEV_ADDR, 8'(a), 8'(d), ok);
    check("write ack", 8'h01, {7'h00, ok});
    // Either reset bit restores every default; else plain storage
    if (a == 0 && (d & 32'h82) != 0) begin
      exp_reg = '{32'h41, 0, 0, 0};
      if ((d & 32'h80) != 0) exp_glob++;
      if ((d & 32'h02) != 0) exp_rsr++;
    end else if (a < 4) begin
      exp_reg[a] = (a == 0) ? (d & 32'h7D) : (d & 32'hFF);
    end
    if ((old & 4) != 0 && (exp_reg[1] & 4) == 0) exp_fclr++;
  endtask : wr
  // Bus read compared with the model; unmapped places read zero
  task automatic rd(input int a);
    logic [7:0] v;
    u_host.read_reg(8'(a), v);
    check("readback", (a < 4) ? 8'(exp_reg[a]) : 8'h00, v);
  endtask : rd
  // =====================================================================
  // Main sequence
  initial begin
    logic ok;
    void'($urandom(32'h30CE));
    exp_reg = '{32'h41, 0, 0, 0};
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    check_outputs();
    for (int a = 0; a < 4; a++) begin
      rd(a);
    end
    // Random contents, every range and input-select code
    for (int i = 0; i < 8; i++) begin
      wr(1, ($urandom & 32'h9F) | ((i & 3) << 5));
      wr(2, $urandom & 32'hFF);
      wr(3, ($urandom & 32'hF8) | i);
      check_outputs();
      for (int a = 1; a < 4; a++) begin
        rd(a);
      end
    end
    // Chip disable, reserved storage, self-clearing bits read zero
    wr(0, $urandom & 32'h7C);
    check_outputs();
    rd(0);
    wr(0, 32'h7D);
    rd(0);
    // Fault release by clearing and setting bias, then register reset
    wr(1, 32'h04);
    wr(1, 32'h00);
    wr(1, 32'h04);
    wr(3, 32'hD3);
    wr(0, 32'h02);
    check_outputs();
    rd(0);
    rd(3);
    // Global reset from busy contents
    wr(2, 32'h03);
    wr(1, 32'hFB);
    wr(0, 32'h80);
    check_outputs();
    rd(2);
    // Foreign address refused, unmapped register ignored
    u_host.write_reg(CCR_DEV_ADDR ^ 7'h01, CCR_ADDR_TX, 8'hFF, ok);
    check("foreign ack", 8'h00, {7'h00, ok});
    u_host.write_reg(CCR_DEV_ADDR, 8'h04, 8'hAA, ok);
    rd(4);
    rd(1);
    // Reset in mid-run restores defaults
    wr(2, 32'h01);
    wr(3, 32'h90);
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    exp_reg = '{32'h41, 0, 0, 0};
    check_outputs();
    rd(3);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
